// [rtl/pwm_map.svh]
// Purpose: Register offsets, field positions and reset values of the PWM unit.
// Assumes: 8-bit special-function-register bus with byte addresses.
// Notes: Definitions only.
`ifndef PWM_MAP_SVH
`define PWM_MAP_SVH
`define ADDR_IRQ_ENABLE_EXT 8'hA9
`define ADDR_IRQ_PRIORITY_EXT 8'hB9
`define ADDR_PWM_CONFIG 8'hD1
`define ADDR_PWM_CONTROL 8'hD2
`define ADDR_PWM_PERIOD 8'hD3
`define ADDR_PWM_DUTY_FINE 8'hD4
`define ADDR_PWM_DUTY_CH0 8'hD5
`define ADDR_PWM_DUTY_CH1 8'hD6
`define ADDR_PWM_DUTY_CH2 8'hD7
`define CTL_RUN_BIT 7
`define CTL_WRAP_BIT 6
`define CTL_DRIVE_LSB 3
`define CTL_PRESCALE_LSB 0
`define CFG_FLIP_LSB 3
`define CFG_CHOICE_LSB 0
`define IE1_WRAP_BIT 1
`define IE1_MASK 8'h0E
`define FINE_MASK 8'h3F
`define CFG_MASK 8'hFF
`define REG_RESET 8'h00
`define FINE_STEPS 4
`define PRESCALE_MASK_0 8'h00
`define PRESCALE_MASK_1 8'h01
`define PRESCALE_MASK_2 8'h03
`define PRESCALE_MASK_3 8'h07
`define PRESCALE_MASK_4 8'h1F
`define PRESCALE_MASK_5 8'h3F
`define PRESCALE_MASK_6 8'h7F
`define PRESCALE_MASK_7 8'hFF
`endif

// [rtl/pwm_pkg.sv]
// Purpose: Types shared by the PWM unit modules.
// Assumes: Three channels with 8-bit coarse and 2-bit fine duty.
// Notes: Offsets live in pwm_map.svh.
package pwm_pkg;
  typedef logic [7:0] sfr_byte_t;
  typedef logic [2:0] prescale_code_t;
  typedef logic [1:0] fine_t;
endpackage : pwm_pkg

// [rtl/pwm_prescaler.sv]
// Purpose: Divides the system clock into the counter tick.
// Assumes: Code 111 divides by 256.
// Notes: The divider is held at zero while the unit is stopped.
`timescale 1ns/100ps
`include "pwm_map.svh"
module pwm_prescaler #(
  parameter int DIV_W = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control.
  input wire logic run,
  input wire pwm_pkg::prescale_code_t code,
  // Tick out.
  output logic tick
);
  import pwm_pkg::*;
  // The widest division needs eight divider bits.
  if (DIV_W < 8) begin : g_width_chk
    $error("DIV_W too small");
  end
  logic [DIV_W-1:0] div;
  logic [DIV_W-1:0] mask;
  always_comb begin
    unique case (code)
      3'h0: mask = DIV_W'(`PRESCALE_MASK_0);
      3'h1: mask = DIV_W'(`PRESCALE_MASK_1);
      3'h2: mask = DIV_W'(`PRESCALE_MASK_2);
      3'h3: mask = DIV_W'(`PRESCALE_MASK_3);
      3'h4: mask = DIV_W'(`PRESCALE_MASK_4);
      3'h5: mask = DIV_W'(`PRESCALE_MASK_5);
      3'h6: mask = DIV_W'(`PRESCALE_MASK_6);
      3'h7: mask = DIV_W'(`PRESCALE_MASK_7);
    endcase
  end
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      div <= '0;
    end else if ((div & mask) == mask) begin
      div <= '0;
    end else begin
      div <= div + DIV_W'(1);
    end
  end
  assign tick = run && ((div & mask) == mask);
endmodule : pwm_prescaler

// [rtl/pwm_tick_if.sv]
// Purpose: Carries the counter tick and count between the PWM modules.
// Assumes: Single clock domain.
// Notes: The timebase drives, the top listens.
`timescale 1ns/100ps
interface pwm_tick_if;
  logic tick;
  logic [7:0] count;
  logic [1:0] phase;
  logic wrap;
  modport source (output tick, output count, output phase, output wrap);
  modport sink (input tick, input count, input phase, input wrap);
endinterface : pwm_tick_if

// [rtl/pwm_timebase.sv]
// Purpose: Shared period counter with a fine phase for 8+2-bit duty.
// Assumes: Tick comes from the prescaler.
// Notes: Each coarse step is split into four fine phases across periods.
`timescale 1ns/100ps
`include "pwm_map.svh"
module pwm_timebase (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Control.
  input wire logic run,
  input wire pwm_pkg::sfr_byte_t period_limit,
  input wire logic tick,
  // Counter out.
  pwm_tick_if.source tb
);
  import pwm_pkg::*;
  logic [7:0] count;
  logic [1:0] phase;
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      count <= '0;
    end else if (tick && count >= period_limit) begin
      count <= '0;
    end else if (tick) begin
      count <= count + 8'h01;
    end
  end
  // The fine phase advances once per period so each fine step stretches one period in four.
  always_ff @(posedge clk) begin
    if (rst || !run) begin
      phase <= '0;
    end else if (tick && count >= period_limit) begin
      phase <= phase + 2'h1;
    end
  end
  assign tb.tick = tick;
  assign tb.count = count;
  assign tb.phase = phase;
  assign tb.wrap = run && tick && (count >= period_limit);
endmodule : pwm_timebase

// [rtl/pwm_unit.sv]
// Purpose: Three-channel PWM with one shared period counter and SFR access.
// Assumes: The CPU writes and reads registers through a byte SFR port.
// Notes: Pins show drive value and an active-low output enable per pin.
`timescale 1ns/100ps
`include "pwm_map.svh"
module pwm_unit #(
  parameter int CHANNELS = 3
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Special function register port.
  input wire pwm_pkg::sfr_byte_t sfr_addr,
  input wire pwm_pkg::sfr_byte_t sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output pwm_pkg::sfr_byte_t sfr_rdata,
  // Interrupt request and priority.
  output logic wrap_irq,
  output logic wrap_irq_priority,
  // Primary pins.
  output logic [CHANNELS-1:0] pin_primary,
  output logic [CHANNELS-1:0] pin_primary_oe_n,
  // Alternate pins.
  output logic [CHANNELS-1:0] pin_alternate,
  output logic [CHANNELS-1:0] pin_alternate_oe_n
);
  import pwm_pkg::*;
  // Register fields and read decode are laid out for exactly three channels.
  if (CHANNELS != 3) begin : g_channels_chk
    $error("CHANNELS must be 3");
  end

  sfr_byte_t pwm_control;
  sfr_byte_t pwm_config;
  sfr_byte_t pwm_period;
  sfr_byte_t pwm_duty_fine;
  sfr_byte_t irq_enable_ext;
  sfr_byte_t irq_priority_ext;
  sfr_byte_t high_count [CHANNELS];

  logic unit_run_enable;
  logic counter_wrap_flag;
  logic [CHANNELS-1:0] pin_drive_on;
  logic [CHANNELS-1:0] polarity_flip;
  logic [CHANNELS-1:0] pin_choice;
  prescale_code_t prescale_select;
  logic tick;

  assign unit_run_enable = pwm_control[`CTL_RUN_BIT];
  assign counter_wrap_flag = pwm_control[`CTL_WRAP_BIT];
  assign pin_drive_on = pwm_control[`CTL_DRIVE_LSB +: 3];
  assign prescale_select = pwm_control[`CTL_PRESCALE_LSB +: 3];
  assign polarity_flip = pwm_config[`CFG_FLIP_LSB +: 3];
  assign pin_choice = pwm_config[`CFG_CHOICE_LSB +: 3];

  pwm_tick_if tb_bus ();

  pwm_prescaler #(
    .DIV_W(8)
  ) u_prescaler (
    .clk(clk),
    .rst(rst),
    .run(unit_run_enable),
    .code(prescale_select),
    .tick(tick)
  );

  pwm_timebase u_timebase (
    .clk(clk),
    .rst(rst),
    .run(unit_run_enable),
    .period_limit(pwm_period),
    .tick(tick),
    .tb(tb_bus.source)
  );

  // Control register: the wrap flag is set by hardware and cleared only by a zero write.
  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_control <= `REG_RESET;
    end else begin
      if (sfr_wr && sfr_addr == `ADDR_PWM_CONTROL) begin
        pwm_control <= sfr_wdata;
      end
      if (tb_bus.wrap) begin
        pwm_control[`CTL_WRAP_BIT] <= 1'b1;
      end
    end
  end

  // Plain read/write registers.
  always_ff @(posedge clk) begin
    if (rst) begin
      pwm_config <= `REG_RESET;
      pwm_period <= `REG_RESET;
      pwm_duty_fine <= `REG_RESET;
      irq_enable_ext <= `REG_RESET;
      irq_priority_ext <= `REG_RESET;
    end else if (sfr_wr) begin
      unique case (sfr_addr)
        `ADDR_PWM_CONFIG: pwm_config <= sfr_wdata & `CFG_MASK;
        `ADDR_PWM_PERIOD: pwm_period <= sfr_wdata;
        `ADDR_PWM_DUTY_FINE: pwm_duty_fine <= sfr_wdata & `FINE_MASK;
        `ADDR_IRQ_ENABLE_EXT: irq_enable_ext <= sfr_wdata & `IE1_MASK;
        `ADDR_IRQ_PRIORITY_EXT: irq_priority_ext <= sfr_wdata & `IE1_MASK;
        default: ;
      endcase
    end
  end

  // Per-channel coarse duty, shaping and pin routing.
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_ch
    logic [7:0] addr_duty;
    fine_t fine_bits;
    logic raw_high;
    logic shaped;
    assign addr_duty = `ADDR_PWM_DUTY_CH0 + 8'(ch);
    assign fine_bits = pwm_duty_fine[2*ch +: 2];

    always_ff @(posedge clk) begin
      if (rst) begin
        high_count[ch] <= `REG_RESET;
      end else if (sfr_wr && sfr_addr == addr_duty) begin
        high_count[ch] <= sfr_wdata;
      end
    end

    // High for the coarse count, plus one extra count in fine_bits of every four periods.
    always_comb begin
      raw_high = (tb_bus.count < high_count[ch]) ||
                 ((tb_bus.count == high_count[ch]) && (tb_bus.phase < fine_bits));
      shaped = raw_high ^ polarity_flip[ch];
    end

    always_ff @(posedge clk) begin
      if (rst) begin
        pin_primary[ch] <= 1'b0;
        pin_alternate[ch] <= 1'b0;
        pin_primary_oe_n[ch] <= 1'b1;
        pin_alternate_oe_n[ch] <= 1'b1;
      end else begin
        pin_primary[ch] <= shaped;
        pin_alternate[ch] <= shaped;
        pin_primary_oe_n[ch] <= !(pin_drive_on[ch] && !pin_choice[ch]);
        pin_alternate_oe_n[ch] <= !(pin_drive_on[ch] && pin_choice[ch]);
      end
    end
  end

  // Interrupt request follows the sticky flag and its enable.
  always_ff @(posedge clk) begin
    if (rst) begin
      wrap_irq <= 1'b0;
      wrap_irq_priority <= 1'b0;
    end else begin
      wrap_irq <= (counter_wrap_flag || tb_bus.wrap) && irq_enable_ext[`IE1_WRAP_BIT];
      wrap_irq_priority <= irq_priority_ext[`IE1_WRAP_BIT];
    end
  end

  // Registered read data; unmapped addresses read zero.
  always_ff @(posedge clk) begin
    if (rst) begin
      sfr_rdata <= `REG_RESET;
    end else if (sfr_rd) begin
      unique case (sfr_addr)
        `ADDR_PWM_CONTROL: sfr_rdata <= pwm_control;
        `ADDR_PWM_CONFIG: sfr_rdata <= pwm_config;
        `ADDR_PWM_PERIOD: sfr_rdata <= pwm_period;
        `ADDR_PWM_DUTY_FINE: sfr_rdata <= pwm_duty_fine;
        `ADDR_PWM_DUTY_CH0: sfr_rdata <= high_count[0];
        `ADDR_PWM_DUTY_CH1: sfr_rdata <= high_count[1];
        `ADDR_PWM_DUTY_CH2: sfr_rdata <= high_count[2];
        `ADDR_IRQ_ENABLE_EXT: sfr_rdata <= irq_enable_ext;
        `ADDR_IRQ_PRIORITY_EXT: sfr_rdata <= irq_priority_ext;
        default: sfr_rdata <= `REG_RESET;
      endcase
    end
  end
endmodule : pwm_unit

// [tb/pwm_cpu_model.sv]
// Purpose: CPU side model that issues register writes and reads.
// Assumes: Signals change on the falling clock edge.
// Notes: A released bus shows the inverse of its last value.
`timescale 1ns/100ps
module pwm_cpu_model (
  // Clock.
  input wire logic clk,
  // Register port.
  input wire pwm_pkg::sfr_byte_t sfr_rdata,
  output pwm_pkg::sfr_byte_t sfr_addr,
  output pwm_pkg::sfr_byte_t sfr_wdata,
  output logic sfr_wr,
  output logic sfr_rd
);
  import pwm_pkg::*;
  initial begin
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
  end
  // Pins are freed and the flag cleared only by writes from here.
  task automatic xfer(input logic w, r, input sfr_byte_t a, d, output sfr_byte_t q);
    @(negedge clk);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = w;
    sfr_rd = r & ~w;
    if (w & r) begin
      @(negedge clk);
      sfr_wr = 1'b0;
      sfr_rd = 1'b1;
    end
    @(negedge clk);
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    q = sfr_rdata;
    sfr_addr = ~a;
    sfr_wdata = ~d;
  endtask : xfer
endmodule : pwm_cpu_model

// [tb/pwm_unit_monitor.sv]
// Purpose: Port checks of the PWM unit.
// Assumes: Synchronous active-high reset.
// Notes: Bound to every pwm_unit.
`timescale 1ns/100ps
module pwm_unit_monitor #(
  parameter int CHANNELS = 3
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Register port.
  input wire pwm_pkg::sfr_byte_t sfr_addr,
  input wire pwm_pkg::sfr_byte_t sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire pwm_pkg::sfr_byte_t sfr_rdata,
  // Interrupt.
  input wire logic wrap_irq,
  input wire logic wrap_irq_priority,
  // Pins.
  input wire logic [CHANNELS-1:0] pin_primary,
  input wire logic [CHANNELS-1:0] pin_primary_oe_n,
  input wire logic [CHANNELS-1:0] pin_alternate,
  input wire logic [CHANNELS-1:0] pin_alternate_oe_n
);
  import pwm_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  property p_rst_irq;
    $fell(rst) |-> !wrap_irq && sfr_rdata == 8'h00;
  endproperty
  property p_rst_oe;
    $fell(rst) |-> &pin_primary_oe_n && &pin_alternate_oe_n;
  endproperty
  property p_one_pin;
    &(pin_primary_oe_n | pin_alternate_oe_n);
  endproperty
  property p_oe_quiet;
    !sfr_wr [*2] |=> $stable(pin_primary_oe_n) && $stable(pin_alternate_oe_n);
  endproperty
  property p_rd_back;
    sfr_wr && sfr_addr == 8'hD5 ##1 sfr_rd && sfr_addr == 8'hD5
      |=> sfr_rdata == $past(sfr_wdata, 2);
  endproperty
  property p_irq_hold;
    !sfr_wr [*2] ##0 wrap_irq |=> wrap_irq;
  endproperty
  property p_irq_mask;
    sfr_wr && sfr_addr == 8'hA9 && !sfr_wdata[1] ##1 !sfr_wr |=> !wrap_irq;
  endproperty
  property p_unmapped;
    sfr_rd && sfr_addr == 8'h00 |=> sfr_rdata == 8'h00;
  endproperty
  a_rst_irq: assert property (p_rst_irq) else $error("reset irq");
  a_rst_oe: assert property (p_rst_oe) else $error("reset pins");
  a_one_pin: assert property (p_one_pin) else $error("two pins");
  a_oe_quiet: assert property (p_oe_quiet) else $error("pin enable moved");
  a_rd_back: assert property (p_rd_back) else $error("duty readback");
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");
  a_irq_mask: assert property (p_irq_mask) else $error("irq unmasked");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  c_irq: cover property ($rose(wrap_irq));
  c_alt: cover property (!pin_alternate_oe_n[0]);
  c_ctl_rd: cover property (sfr_rd && sfr_addr == 8'hD2);
endmodule : pwm_unit_monitor

bind pwm_unit pwm_unit_monitor #(.CHANNELS(CHANNELS)) i_mon (.clk(clk), .rst(rst),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
  .sfr_rdata(sfr_rdata), .wrap_irq(wrap_irq), .wrap_irq_priority(wrap_irq_priority),
  .pin_primary(pin_primary), .pin_primary_oe_n(pin_primary_oe_n),
  .pin_alternate(pin_alternate), .pin_alternate_oe_n(pin_alternate_oe_n));

// [tb/pwm_unit_tb.sv]
// Purpose: Self-checking bench for the PWM unit.
// Assumes: Inputs change on the falling clock edge.
// Notes: High time is summed over whole periods.
`timescale 1ns/100ps
module pwm_unit_tb;
  import pwm_pkg::*;
  logic clk, rst, sfr_wr, sfr_rd, wrap_irq, wrap_irq_priority;
  sfr_byte_t sfr_addr, sfr_wdata, sfr_rdata;
  logic [2:0] pin_primary, pin_primary_oe_n, pin_alternate, pin_alternate_oe_n;
  int error_cnt = 0;
  int num_checks = 0;
  sfr_byte_t regs[10] = '{8'hD1, 8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hD6, 8'hD7, 8'hA9, 8'hB9, 8'h00};
  // A channel counts as high only on the pin that it drives.
  wire logic [2:0] seen = (~pin_primary_oe_n & pin_primary) | (~pin_alternate_oe_n & pin_alternate);
  pwm_unit i_dut (.clk(clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .wrap_irq(wrap_irq),
    .wrap_irq_priority(wrap_irq_priority), .pin_primary(pin_primary),
    .pin_primary_oe_n(pin_primary_oe_n), .pin_alternate(pin_alternate),
    .pin_alternate_oe_n(pin_alternate_oe_n));
  pwm_cpu_model i_cpu (.clk(clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr),
    .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input logic [15:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input sfr_byte_t a, d);
    sfr_byte_t q;
    i_cpu.xfer(1'b1, 1'b0, a, d, q);
  endtask : wr
  task automatic rc(input logic w, input sfr_byte_t a, d, e);
    sfr_byte_t q;
    i_cpu.xfer(w, 1'b1, a, d, q);
    chk(16'(q), 16'(e));
  endtask : rc
  task automatic ms(input int s, n, e0, e1, e2);
    logic [15:0] h[3];
    h = '{16'h0000, 16'h0000, 16'h0000};
    repeat (s) @(negedge clk);
    repeat (n) begin
      @(negedge clk);
      for (int c = 0; c < 3; c++) h[c] += 16'(seen[c]);
    end
    chk(h[0], 16'(e0));
    chk(h[1], 16'(e1));
    chk(h[2], 16'(e2));
  endtask : ms
  initial begin
    repeat (20000) @(negedge clk);
    error_cnt++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    foreach (regs[i]) rc(1'b0, regs[i], 8'h00, 8'h00);
    rc(1'b1, 8'hD5, 8'hA5, 8'hA5);
    rc(1'b1, 8'hD4, 8'hFF, 8'h3F);
    rc(1'b1, 8'hA9, 8'hFF, 8'h0E);
    chk(16'(wrap_irq_priority), 16'h0000);
    rc(1'b1, 8'hB9, 8'hFF, 8'h0E);
    chk(16'(wrap_irq_priority), 16'h0001);
    rc(1'b1, 8'h00, 8'hFF, 8'h00);
    wr(8'hA9, 8'h00);
    wr(8'hD4, 8'h00);
    wr(8'hD3, 8'h04);
    wr(8'hD5, 8'h01);
    wr(8'hD6, 8'h03);
    wr(8'hD7, 8'h05);
    wr(8'hD2, 8'hB8);
    ms(8, 20, 4, 12, 20);
    wr(8'hD4, 8'h1B);
    ms(8, 20, 7, 14, 20);
    wr(8'hD1, 8'h3F);
    ms(8, 20, 13, 6, 0);
    chk(16'({pin_primary_oe_n, pin_alternate_oe_n}), 16'h0038);
    wr(8'hD2, 8'hA8);
    @(negedge clk);
    chk(16'({pin_primary_oe_n, pin_alternate_oe_n}), 16'h003A);
    wr(8'hD1, 8'h00);
    wr(8'hD4, 8'h00);
    wr(8'hD3, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(8'hD2, 8'h88 | 8'(i));
      ms(4 * (i < 4 ? 1 << i : 2 << i), 4 * (i < 4 ? 1 << i : 2 << i),
        2 * (i < 4 ? 1 << i : 2 << i), 0, 0);
    end
    rc(1'b0, 8'hD2, 8'h00, 8'hCF);
    wr(8'hA9, 8'h02);
    repeat (2) @(negedge clk);
    chk(16'(wrap_irq), 16'h0001);
    wr(8'hA9, 8'h00);
    repeat (2) @(negedge clk);
    chk(16'(wrap_irq), 16'h0000);
    wr(8'hD3, 8'hFF);
    wr(8'hD2, 8'h08);
    rc(1'b0, 8'hD2, 8'h00, 8'h08);
    wr(8'hA9, 8'h02);
    repeat (2) @(negedge clk);
    chk(16'({wrap_irq, pin_primary[0]}), 16'h0001);
    end_sim();
  end
endmodule : pwm_unit_tb
